// *** design/ggc_defines.svh ***
// constants of the global clock and control block
`ifndef GGC_DEFINES_SVH
`define GGC_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define GGC_CLOCK_HZ          100000000
`define GGC_RESET_MIN_NS      100
`define GGC_READY_DELAY_MS    2
`define GGC_READY_CYCLES      (`GGC_READY_DELAY_MS * (`GGC_CLOCK_HZ / 1000))

// ----------------------------------------
// clock generator
// ----------------------------------------
`define GGC_RATE_W            14
`define GGC_T1_RATE_KHZ       14'h0608
`define GGC_E1_RATE_KHZ       14'h0800
`define GGC_MULT_BASE         3'h1
`define GGC_CLKSEL_FAMILY_BIT 2

// ----------------------------------------
// widths
// ----------------------------------------
`define GGC_ADDR_W            10
`define GGC_DATA_W            8
`define GGC_LINKS             4
`define GGC_GPIO_W            2

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define GGC_OFS_GPIO_CTRL     10'h006
`define GGC_OFS_REF_SEL       10'h007
`define GGC_OFS_REF_FALLBACK  10'h03e
`define GGC_GPIO_DIR_LSB      0
`define GGC_GPIO_LEVEL_LSB    2
`define GGC_REF_FIRST_LSB     0
`define GGC_REF_SECOND_LSB    3
`define GGC_FALLBACK_HIGH_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define GGC_GPIO_DIR_RESET    2'h0
`define GGC_GPIO_LEVEL_RESET  2'h0
`define GGC_REF_CHOICE_RESET  2'h0
`define GGC_FALLBACK_RESET    1'h0
`define GGC_HOST_IDLE         21'h1c0000
`define GGC_PIN_SYNC_RESET    11'h400

`endif

// *** design/ggc_pkg.sv ***
// types shared by the global clock and control block
package ggc_pkg;
`include "ggc_defines.svh"

	// host parallel port pins, sampled together
	typedef struct packed {
		logic                   cs_n;
		logic                   rd_n;
		logic                   wr_n;
		logic [`GGC_ADDR_W-1:0] addr;
		logic [`GGC_DATA_W-1:0] wdata;
	} ggc_host_bus_type;

	// software visible control fields
	typedef struct packed {
		logic [`GGC_GPIO_W-1:0] gpio_dir;
		logic [`GGC_GPIO_W-1:0] gpio_level;
		logic [1:0]             first_ref_link_choice;
		logic [1:0]             second_ref_link_choice;
		logic                   ref_fallback_high_select;
	} ggc_regs_type;

	// register access state, gray along wait-idle-held
	typedef enum logic [1:0] {
		ACC_WAIT = 2'b00,
		ACC_IDLE = 2'b01,
		ACC_HELD = 2'b11
	} ggc_access_state_type;

endpackage : ggc_pkg

// *** design/ggc_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ggc_sync #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	// pins and filtered levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);

	// stage1 feeds stage2 only; a bit moves once stages two and three agree
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= RESET_VALUE;
			stage2 <= RESET_VALUE;
			stage3 <= RESET_VALUE;
			level  <= RESET_VALUE;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= (level & ~agree) | (stage3 & agree);
		end
	end
endmodule : ggc_sync

// *** design/ggc_rate_gen.sv ***
// fractional edge divider: toggles its output at step/modulus of the tick rate
`timescale 1ns/1ps
module ggc_rate_gen #(
	parameter int WIDTH = 14
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	// rate control
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] step,
	input  wire logic [WIDTH-1:0] modulus,
	// generated clock
	output logic                  clk_out
);
	logic [WIDTH-1:0] acc;
	wire  [WIDTH:0]   sum  = {1'b0, acc} + {1'b0, step};
	wire              wrap = sum >= {1'b0, modulus};
	wire  [WIDTH-1:0] next_acc = wrap ? WIDTH'(sum - {1'b0, modulus}) : sum[WIDTH-1:0];

	// a step that divides the modulus evenly gives a plain divide; any other smaller step gives a dithered rate
	// limitation: one toggle per tick at most, so a rate above the master rate saturates at it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			acc     <= '0;
			clk_out <= 1'b0;
		end else if (tick) begin
			acc     <= next_acc;
			clk_out <= clk_out ^ wrap;
		end
	end
endmodule : ggc_rate_gen

// *** design/ggc_top.sv ***
// chip level clock, reference routing and control pins with host registers
`timescale 1ns/1ps
`include "ggc_defines.svh"
module ggc_top #(
	parameter int READY_CYCLES = `GGC_READY_CYCLES
) (
	// clock and reset
	input  wire logic                      CLOCK,
	input  wire logic                      RESET_N,
	// master clock and its selection pins
	input  wire logic                      MASTER_CLOCK_IN,
	input  wire logic [2:0]                CLOCK_SELECT,
	output logic                           INVERTED_CLOCK_OUT,
	output logic                           GEN_OUT_T1_RATE,
	output logic                           GEN_OUT_E1_RATE,
	// recovered clocks and reference outputs
	input  wire logic [`GGC_LINKS-1:0]     RECOVERED_CLOCK,
	input  wire logic [`GGC_LINKS-1:0]     SIGNAL_LOSS,
	output logic                           RECOVERED_REF_FIRST,
	output logic                           RECOVERED_REF_SECOND,
	// host register port
	input  wire ggc_pkg::ggc_host_bus_type HOST_BUS,
	output logic [`GGC_DATA_W-1:0]         HOST_DATA_OUT,
	output logic                           HOST_DATA_OE,
	// general purpose pins
	input  wire logic [`GGC_GPIO_W-1:0]    GPIO_IN,
	output logic [`GGC_GPIO_W-1:0]         GPIO_OUT,
	output logic [`GGC_GPIO_W-1:0]         GPIO_OE,
	// line driver pairs
	input  wire logic                      LINE_DRIVER_TRISTATE,
	input  wire logic [`GGC_LINKS-1:0]     LINE_POS_DATA,
	input  wire logic [`GGC_LINKS-1:0]     LINE_NEG_DATA,
	output logic [`GGC_LINKS-1:0]          LINE_OUT_POSITIVE,
	output logic [`GGC_LINKS-1:0]          LINE_OUT_NEGATIVE,
	output logic [`GGC_LINKS-1:0]          LINE_OUT_OE,
	// interrupt
	input  wire logic [`GGC_LINKS-1:0]     INTERRUPT_SOURCE,
	output logic                           INTERRUPT_N_OUT,
	output logic                           INTERRUPT_N_OE
);
	import ggc_pkg::*;

	localparam int CNT_W = $clog2(READY_CYCLES + 1);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic                   master_sync;
	logic [2:0]             clock_select_sync;
	logic [`GGC_LINKS-1:0]  recovered_sync;
	logic [`GGC_GPIO_W-1:0] gpio_sync;
	logic                   tristate_sync;
	ggc_host_bus_type       host;

	// every pin here is asynchronous to CLOCK; tristate comes up high so the pairs float until the pin is known
	ggc_sync #(
		.WIDTH       (11),
		.RESET_VALUE (`GGC_PIN_SYNC_RESET)
	) u_pin_sync (
		.clock    (CLOCK),
		.reset_n  (RESET_N),
		.async_in ({LINE_DRIVER_TRISTATE, GPIO_IN, RECOVERED_CLOCK, CLOCK_SELECT, MASTER_CLOCK_IN}),
		.level    ({tristate_sync, gpio_sync, recovered_sync, clock_select_sync, master_sync})
	);

	// strobes come up inactive so no access is seen at reset
	ggc_sync #(
		.WIDTH       ($bits(ggc_host_bus_type)),
		.RESET_VALUE (`GGC_HOST_IDLE)
	) u_host_sync (
		.clock    (CLOCK),
		.reset_n  (RESET_N),
		.async_in (HOST_BUS),
		.level    (host)
	);

	// ----------------------------------------
	// master clock edges
	// ----------------------------------------
	logic master_prev;

	// both edges count, so a divide by one still toggles once per half period
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			master_prev <= 1'b0;
		end else begin
			master_prev <= master_sync;
		end
	end

	wire master_tick = master_sync ^ master_prev;

	// inverted copy; it lags the pin by the synchroniser delay plus one register
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			INVERTED_CLOCK_OUT <= 1'b1;
		end else begin
			INVERTED_CLOCK_OUT <= ~master_sync;
		end
	end

	// ----------------------------------------
	// clock generator
	// ----------------------------------------
	// modulus is the master rate in kHz, so each output steps by its own rate
	wire                  family_e1 = clock_select_sync[`GGC_CLKSEL_FAMILY_BIT];
	wire [2:0]            mult_n = {1'b0, clock_select_sync[1:0]} + `GGC_MULT_BASE;
	wire [`GGC_RATE_W-1:0] family_rate = family_e1 ? `GGC_E1_RATE_KHZ : `GGC_T1_RATE_KHZ;
	wire [`GGC_RATE_W-1:0] rate_modulus = `GGC_RATE_W'(family_rate * mult_n);

	// same family is an exact divide by N; the other family is dithered, except e1 on a T1 master at N = 1, which saturates at the master rate
	ggc_rate_gen #(
		.WIDTH (`GGC_RATE_W)
	) u_t1_gen (
		.clock   (CLOCK),
		.reset_n (RESET_N),
		.tick    (master_tick),
		.step    (`GGC_T1_RATE_KHZ),
		.modulus (rate_modulus),
		.clk_out (GEN_OUT_T1_RATE)
	);

	ggc_rate_gen #(
		.WIDTH (`GGC_RATE_W)
	) u_e1_gen (
		.clock   (CLOCK),
		.reset_n (RESET_N),
		.tick    (master_tick),
		.step    (`GGC_E1_RATE_KHZ),
		.modulus (rate_modulus),
		.clk_out (GEN_OUT_E1_RATE)
	);

	// ----------------------------------------
	// registers and access control
	// ----------------------------------------
	ggc_regs_type         regs;
	ggc_regs_type         next_regs;
	ggc_access_state_type acc_state;
	ggc_access_state_type next_acc_state;
	logic [CNT_W-1:0]     ready_count;

	// address decode and strobes
	wire ready_done = ready_count == CNT_W'(READY_CYCLES - 1);
	wire host_sel   = !host.cs_n;
	wire write_req  = host_sel && !host.wr_n;
	wire read_req   = host_sel && !host.rd_n && acc_state != ACC_WAIT;
	wire write_now  = acc_state == ACC_IDLE && write_req;
	wire hit_gpio   = host.addr == `GGC_OFS_GPIO_CTRL;
	wire hit_sel    = host.addr == `GGC_OFS_REF_SEL;
	wire hit_fb     = host.addr == `GGC_OFS_REF_FALLBACK;

	// a held write strobe stores once; the next needs the strobe to rise
	always_comb begin
		next_acc_state = acc_state;
		unique case (acc_state)
			ACC_WAIT: next_acc_state = ready_done ? ACC_IDLE : ACC_WAIT;
			ACC_IDLE: next_acc_state = write_req ? ACC_HELD : ACC_IDLE;
			ACC_HELD: next_acc_state = write_req ? ACC_HELD : ACC_IDLE;
			default:  next_acc_state = ACC_WAIT;
		endcase
	end

	// field updates on a write
	always_comb begin
		next_regs = regs;
		if (write_now && hit_gpio) begin
			next_regs.gpio_dir   = host.wdata[`GGC_GPIO_DIR_LSB +: `GGC_GPIO_W];
			next_regs.gpio_level = host.wdata[`GGC_GPIO_LEVEL_LSB +: `GGC_GPIO_W];
		end
		if (write_now && hit_sel) begin
			next_regs.first_ref_link_choice  = host.wdata[`GGC_REF_FIRST_LSB +: 2];
			next_regs.second_ref_link_choice = host.wdata[`GGC_REF_SECOND_LSB +: 2];
		end
		if (write_now && hit_fb) begin
			next_regs.ref_fallback_high_select = host.wdata[`GGC_FALLBACK_HIGH_BIT];
		end
	end

	// any low reset restarts the settling delay from zero
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			acc_state   <= ACC_WAIT;
			ready_count <= '0;
		end else begin
			acc_state   <= next_acc_state;
			ready_count <= (acc_state == ACC_WAIT) ? ready_count + 1'b1 : '0;
		end
	end

	// control fields
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			regs.gpio_dir                 <= `GGC_GPIO_DIR_RESET;
			regs.gpio_level               <= `GGC_GPIO_LEVEL_RESET;
			regs.first_ref_link_choice    <= `GGC_REF_CHOICE_RESET;
			regs.second_ref_link_choice   <= `GGC_REF_CHOICE_RESET;
			regs.ref_fallback_high_select <= `GGC_FALLBACK_RESET;
		end else begin
			regs <= next_regs;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// input pins show the live level, output pins the stored one
	wire [`GGC_GPIO_W-1:0] level_view = (regs.gpio_dir & regs.gpio_level) | (~regs.gpio_dir & gpio_sync);
	wire [`GGC_DATA_W-1:0] gpio_word = (`GGC_DATA_W'(regs.gpio_dir) << `GGC_GPIO_DIR_LSB)
		| (`GGC_DATA_W'(level_view) << `GGC_GPIO_LEVEL_LSB);
	wire [`GGC_DATA_W-1:0] sel_word = (`GGC_DATA_W'(regs.first_ref_link_choice) << `GGC_REF_FIRST_LSB)
		| (`GGC_DATA_W'(regs.second_ref_link_choice) << `GGC_REF_SECOND_LSB);
	wire [`GGC_DATA_W-1:0] fb_word = `GGC_DATA_W'(regs.ref_fallback_high_select) << `GGC_FALLBACK_HIGH_BIT;
	wire [`GGC_DATA_W-1:0] read_word = hit_gpio ? gpio_word :
		hit_sel ? sel_word :
		hit_fb ? fb_word : '0;

	// data bus driven only while a read strobe is seen after the delay
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			HOST_DATA_OUT <= '0;
			HOST_DATA_OE  <= 1'b0;
		end else begin
			HOST_DATA_OUT <= read_word;
			HOST_DATA_OE  <= read_req;
		end
	end

	// ----------------------------------------
	// reference clock routing
	// ----------------------------------------
	// loss is taken from the link that each output has chosen
	wire first_loss  = SIGNAL_LOSS[regs.first_ref_link_choice];
	wire second_loss = SIGNAL_LOSS[regs.second_ref_link_choice];
	wire fallback    = regs.ref_fallback_high_select ? 1'b1 : master_sync;
	wire next_ref_first  = first_loss ? fallback : recovered_sync[regs.first_ref_link_choice];
	wire next_ref_second = second_loss ? fallback : recovered_sync[regs.second_ref_link_choice];

	// registered so the outputs are glitch free when the selection changes
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			RECOVERED_REF_FIRST  <= 1'b0;
			RECOVERED_REF_SECOND <= 1'b0;
		end else begin
			RECOVERED_REF_FIRST  <= next_ref_first;
			RECOVERED_REF_SECOND <= next_ref_second;
		end
	end

	// ----------------------------------------
	// general purpose pins, line drivers, interrupt
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			GPIO_OUT <= `GGC_GPIO_LEVEL_RESET;
			GPIO_OE  <= `GGC_GPIO_DIR_RESET;
		end else begin
			GPIO_OUT <= regs.gpio_level;
			GPIO_OE  <= regs.gpio_dir;
		end
	end

	// line pairs float from reset until the tristate level is known low
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			LINE_OUT_POSITIVE <= '0;
			LINE_OUT_NEGATIVE <= '0;
			LINE_OUT_OE       <= '0;
		end else begin
			LINE_OUT_POSITIVE <= LINE_POS_DATA;
			LINE_OUT_NEGATIVE <= LINE_NEG_DATA;
			LINE_OUT_OE       <= {`GGC_LINKS{~tristate_sync}};
		end
	end

	// open drain: pull low while any source is still set, release otherwise
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			INTERRUPT_N_OUT <= 1'b1;
			INTERRUPT_N_OE  <= 1'b0;
		end else begin
			INTERRUPT_N_OUT <= ~|INTERRUPT_SOURCE;
			INTERRUPT_N_OE  <= |INTERRUPT_SOURCE;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking ggc_cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);

	inv_clock_copy_a: assert property (##1 INVERTED_CLOCK_OUT == !$past(master_sync))
		else $error("inverted clock output does not follow master clock");

	t1_divide_one_a: assert property (master_tick && clock_select_sync == 3'h0 && $stable(clock_select_sync)
		|=> GEN_OUT_T1_RATE != $past(GEN_OUT_T1_RATE))
		else $error("t1 output missed a master edge at multiplier one");

	e1_divide_one_a: assert property (master_tick && clock_select_sync == 3'h4 && $stable(clock_select_sync)
		|=> GEN_OUT_E1_RATE != $past(GEN_OUT_E1_RATE))
		else $error("e1 output missed a master edge at multiplier one");

	gen_quiet_idle_a: assert property (!master_tick |=> $stable(GEN_OUT_T1_RATE) && $stable(GEN_OUT_E1_RATE))
		else $error("generated clock moved without a master edge");

	ref_first_route_a: assert property (!first_loss
		|=> RECOVERED_REF_FIRST == $past(recovered_sync[regs.first_ref_link_choice]))
		else $error("first reference not routed from selected link");

	ref_second_route_a: assert property (!second_loss
		|=> RECOVERED_REF_SECOND == $past(recovered_sync[regs.second_ref_link_choice]))
		else $error("second reference not routed from selected link");

	ref_fallback_a: assert property (first_loss && !regs.ref_fallback_high_select
		|=> RECOVERED_REF_FIRST == $past(master_sync))
		else $error("first reference not on master clock during loss");

	ref_high_a: assert property (second_loss && regs.ref_fallback_high_select |=> RECOVERED_REF_SECOND)
		else $error("second reference not high during loss");

	early_access_a: assert property (acc_state == ACC_WAIT |=> !HOST_DATA_OE && $stable(regs))
		else $error("register access served before settling delay");

	gpio_report_a: assert property (read_req && hit_gpio
		|=> (HOST_DATA_OUT[`GGC_GPIO_LEVEL_LSB +: `GGC_GPIO_W] & ~$past(regs.gpio_dir))
		== ($past(gpio_sync) & ~$past(regs.gpio_dir)))
		else $error("input pin level not reported");

	gpio_drive_a: assert property (##1 GPIO_OE == $past(regs.gpio_dir)
		&& (GPIO_OUT & GPIO_OE) == ($past(regs.gpio_level) & $past(regs.gpio_dir)))
		else $error("general purpose pin drive wrong");

	line_float_a: assert property (tristate_sync |=> LINE_OUT_OE == '0)
		else $error("line driver enabled while tristate high");

	irq_hold_a: assert property (|INTERRUPT_SOURCE |=> INTERRUPT_N_OE && !INTERRUPT_N_OUT)
		else $error("interrupt released while a source is set");

	irq_release_a: assert property (!(|INTERRUPT_SOURCE) |=> !INTERRUPT_N_OE)
		else $error("interrupt held with no source set");

endmodule : ggc_top

// *** tb/ggc_host_model.sv ***
// host processor and master clock source facing the clock and control block
`timescale 1ns/1ps
`include "ggc_defines.svh"
module ggc_host_model (
	// clock
	input  wire logic                 clock,
	// host parallel port
	output ggc_pkg::ggc_host_bus_type host_bus,
	input  wire logic [7:0]           data_in,
	input  wire logic                 data_oe,
	// master clock pin
	output logic                      master_clock
);
	import ggc_pkg::*;
	real  half_ns    = 80.0;
	logic hold       = 1'b0;
	logic hold_level = 1'b0;

	// free running master clock, or a steady level while held
	initial begin
		master_clock = 1'b0;
		host_bus = `GGC_HOST_IDLE;
		forever begin
			#(half_ns);
			master_clock = hold ? hold_level : ~master_clock;
		end
	end

	// master rate is n times the family rate shown on the select pins
	task automatic set_rate(input logic fam, input int n);
		half_ns = 500.0 / (n * (fam ? 2.048 : 1.544));
	endtask : set_rate

	// address and data lead the strobes by a cycle and trail them by two; released data lines show the inverse
	task automatic write_reg(input logic [9:0] a, input logic [7:0] d);
		@(negedge clock);
		host_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: a, wdata: d};
		@(negedge clock);
		host_bus = '{cs_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0, addr: a, wdata: d};
		repeat (8) @(negedge clock);
		host_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: a, wdata: d};
		repeat (2) @(negedge clock);
		host_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: a, wdata: ~d};
		repeat (6) @(negedge clock);
	endtask : write_reg

	// address leads the strobe; strobe held until two cycles after the falling edge at which the data enable is seen, bounded wait
	task automatic read_reg(input logic [9:0] a, output logic [7:0] d, output logic ok);
		int i;
		ok = 1'b0;
		d = 8'h00;
		@(negedge clock);
		host_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: a, wdata: host_bus.wdata};
		@(negedge clock);
		host_bus = '{cs_n: 1'b0, rd_n: 1'b0, wr_n: 1'b1, addr: a, wdata: host_bus.wdata};
		for (i = 0; i < 12 && !ok; i++) begin
			@(negedge clock);
			if (data_oe === 1'b1) begin
				ok = 1'b1;
				d = data_in;
			end
		end
		repeat (2) @(negedge clock);
		host_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: a, wdata: host_bus.wdata};
		repeat (8) @(negedge clock);
	endtask : read_reg
endmodule : ggc_host_model

// *** tb/tb_top.sv ***
// self-checking bench of the clock and control block
`timescale 1ns/1ps
`include "ggc_defines.svh"
module tb_top;
	import ggc_pkg::*;
	localparam int READY = 64;
	logic             clock = 1'b0, reset_n = 1'b0, tristate = 1'b0, master, inv_out, gen_t1, gen_e1;
	logic [2:0]       clock_select = 3'h4;
	logic [3:0]       recovered = 4'h0, loss = 4'h0, pos = 4'h0, neg = 4'h0, irq_src = 4'h0;
	logic [3:0]       line_p, line_n, line_oe;
	logic [1:0]       gpio_in = 2'h0, gpio_out, gpio_oe;
	logic             ref_first, ref_second, data_oe, irq_out, irq_oe, ok;
	logic [7:0]       data_out, rd;
	ggc_host_bus_type host_bus;
	int               errors = 0, n_compared = 0;

	ggc_top #(.READY_CYCLES(READY)) i_ggc_top (.CLOCK(clock), .RESET_N(reset_n), .MASTER_CLOCK_IN(master),
		.CLOCK_SELECT(clock_select), .INVERTED_CLOCK_OUT(inv_out), .GEN_OUT_T1_RATE(gen_t1),
		.GEN_OUT_E1_RATE(gen_e1), .RECOVERED_CLOCK(recovered), .SIGNAL_LOSS(loss),
		.RECOVERED_REF_FIRST(ref_first), .RECOVERED_REF_SECOND(ref_second), .HOST_BUS(host_bus),
		.HOST_DATA_OUT(data_out), .HOST_DATA_OE(data_oe), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out),
		.GPIO_OE(gpio_oe), .LINE_DRIVER_TRISTATE(tristate), .LINE_POS_DATA(pos), .LINE_NEG_DATA(neg),
		.LINE_OUT_POSITIVE(line_p), .LINE_OUT_NEGATIVE(line_n), .LINE_OUT_OE(line_oe),
		.INTERRUPT_SOURCE(irq_src), .INTERRUPT_N_OUT(irq_out), .INTERRUPT_N_OE(irq_oe));
	ggc_host_model i_ggc_host_model (.clock(clock), .host_bus(host_bus), .data_in(data_out),
		.data_oe(data_oe), .master_clock(master));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	initial begin
		forever #5 clock = ~clock;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic summarize;
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	// a read that never answers ends the run at once
	task automatic rd_expect(input string name, input logic [9:0] a, input logic [7:0] exp);
		i_ggc_host_model.read_reg(a, rd, ok);
		if (!ok) begin
			errors++;
			$display("ERROR %s expected data enable seen none", name);
			summarize();
		end else begin
			check(name, {24'h0, rd}, {24'h0, exp});
		end
	endtask : rd_expect

	function automatic logic near(input int c, input int e);
		return c >= e - 2 && c <= e + 2;
	endfunction : near

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// every family and multiplier: count generated and inverted clock edges over 4000 cycles
	task automatic t_clock_gen;
		int   f, n, i, c1, c2, ci;
		logic p1, p2, pi;
		for (f = 0; f < 2; f++) begin
			for (n = 1; n < 5; n++) begin
				clock_select = {f[0], 2'(n - 1)};
				i_ggc_host_model.set_rate(f[0], n);
				repeat (300) @(negedge clock);
				{c1, c2, ci} = '0;
				{p1, p2, pi} = {gen_t1, gen_e1, inv_out};
				for (i = 0; i < 4000; i++) begin
					@(negedge clock);
					c1 += int'(gen_t1 && !p1);
					c2 += int'(gen_e1 && !p2);
					ci += int'(inv_out && !pi);
					{p1, p2, pi} = {gen_t1, gen_e1, inv_out};
				end
				check("t1_rate_edges", near(c1, 61), 1'b1);
				// a 1.544 MHz master at N = 1 has too few edges for 2.048 MHz: the output saturates at the master rate
				check("e1_rate_edges", near(c2, (f == 0 && n == 1) ? 61 : 81), 1'b1);
				check("inv_clock_edges", near(ci, 40 * n * (f ? 2048 : 1544) / 1000), 1'b1);
			end
		end
	endtask : t_clock_gen

	// each link on each reference, then the loss fallback both ways
	task automatic t_refs;
		int l;
		for (l = 0; l < 4; l++) begin
			i_ggc_host_model.write_reg(10'h007, {3'h0, 2'(3 - l), 1'b0, 2'(l)});
			rd_expect("ref_select_read", 10'h007, {3'h0, 2'(3 - l), 1'b0, 2'(l)});
			recovered = 4'h6 ^ 4'(1 << l);
			repeat (10) @(negedge clock);
			check("ref_first", ref_first, recovered[l]);
			check("ref_second", ref_second, recovered[3 - l]);
			recovered = ~recovered;
			repeat (10) @(negedge clock);
			check("ref_first_flip", ref_first, recovered[l]);
			check("ref_second_flip", ref_second, recovered[3 - l]);
		end
		recovered = 4'h0;
		loss = 4'hf;
		i_ggc_host_model.write_reg(10'h03e, 8'h01);
		check("ref_loss_high", {ref_first, ref_second}, 2'b11);
		i_ggc_host_model.write_reg(10'h03e, 8'h00);
		i_ggc_host_model.hold_level = 1'b1;
		i_ggc_host_model.hold = 1'b1;
		repeat (12) @(negedge clock);
		check("ref_loss_master_high", {ref_first, ref_second, inv_out}, 3'b110);
		i_ggc_host_model.hold_level = 1'b0;
		repeat (12) @(negedge clock);
		check("ref_loss_master_low", {ref_first, ref_second, inv_out}, 3'b001);
		i_ggc_host_model.hold = 1'b0;
		loss = 4'h0;
	endtask : t_refs

	// pin 0 output at level 1, pin 1 input follows its pin
	task automatic t_gpio;
		i_ggc_host_model.write_reg(10'h006, 8'h0d);
		check("gpio_dir", gpio_oe, 2'b01);
		check("gpio_drive", gpio_out[0], 1'b1);
		gpio_in = 2'b00;
		rd_expect("gpio_read_low", 10'h006, 8'h05);
		gpio_in = 2'b10;
		rd_expect("gpio_read_high", 10'h006, 8'h0d);
		rd_expect("unmapped_read", 10'h3ff, 8'h00);
	endtask : t_gpio

	// line pairs float on tristate, interrupt pulls low while any source stands
	task automatic t_line_irq;
		{pos, neg} = 8'h5a;
		repeat (10) @(negedge clock);
		check("line_driven", {line_oe, line_p, line_n}, 12'hf5a);
		tristate = 1'b1;
		irq_src = 4'h4;
		repeat (10) @(negedge clock);
		check("line_floated", line_oe, 4'h0);
		check("irq_asserted", {irq_oe, irq_out}, 2'b10);
		irq_src = 4'h0;
		tristate = 1'b0;
		repeat (3) @(negedge clock);
		check("irq_released", irq_oe, 1'b0);
	endtask : t_line_irq

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		// eight cycles would be only 80 ns, short of the minimum reset pulse
		repeat (11) @(negedge clock);
		reset_n = 1'b1;
		i_ggc_host_model.write_reg(10'h03e, 8'h01);
		repeat (READY + 10) @(negedge clock);
		rd_expect("early_write_refused", 10'h03e, 8'h00);
		t_clock_gen();
		t_refs();
		t_gpio();
		t_line_irq();
		reset_n = 1'b0;
		repeat (11) @(negedge clock);
		reset_n = 1'b1;
		repeat (READY + 10) @(negedge clock);
		rd_expect("select_after_reset", 10'h007, 8'h00);
		rd_expect("gpio_after_reset", 10'h006, 8'h08);
		summarize();
	end
endmodule : tb_top
